//--- hdl/podl_params.svh
// Offsets, reset values and field positions of the pulse output data latch
// Assumes a plain register port with byte-wide data in the low bits
//
// What this block does
// RQ1: Enabled bits copy next data on trigger
// RQ2: Disabled bits hold output on trigger
// RQ3: Enable registers eight bits, RW, reset zero
// RQ4: Enabled output bits ignore CPU writes
// RQ5: Disabled output bits accept CPU writes
// RQ6: Output registers eight bits, readable, reset zero
// RQ7: Trigger chosen by output control register
// RQ8: Four-bit groups with own trigger select
// RQ9: Output pins driven from output data bits
`ifndef PODL_PARAMS_SVH
`define PODL_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PODL_OFS_ENABLE_HIGH 4'h0
`define PODL_OFS_ENABLE_LOW 4'h1
`define PODL_OFS_DATA_HIGH 4'h2
`define PODL_OFS_DATA_LOW 4'h3
`define PODL_OFS_NEXT_HIGH 4'h4
`define PODL_OFS_NEXT_LOW 4'h5
`define PODL_OFS_CONTROL 4'h6

// ****************************************
// Reset values and fields
// ****************************************
`define PODL_RST_BYTE 8'h00
`define PODL_GROUP_BITS 4
`define PODL_SEL_BITS 2

`endif

//--- hdl/podl_pkg.sv
// Types shared by the pulse output data latch
// Assumes nothing of its surroundings
package podl_pkg;
  typedef logic [7:0] podl_byte_t;
  typedef logic [15:0] podl_word_t;
endpackage

//--- hdl/podl_group.sv
// One four-bit group: output data bits with per-bit transfer enable
// Assumes the trigger pulse is one cycle long and synchronous to clk_in
`timescale 1ns/10ps
`include "podl_params.svh"
module podl_group #(
  parameter int WIDTH = `PODL_GROUP_BITS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic trigger_in,
  input wire logic [WIDTH-1:0] enable_in,
  input wire logic [WIDTH-1:0] next_in,
  input wire logic write_in,
  input wire logic [WIDTH-1:0] wdata_in,
  output logic [WIDTH-1:0] data_out
);
  // ****************************************
  // Per-bit output latch
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          data_out[i] <= 1'b0; // RQ6
        end else if (enable_in[i]) begin
          if (trigger_in) begin
            data_out[i] <= next_in[i]; // RQ1 RQ4 RQ9
          end
        end else if (write_in) begin
          data_out[i] <= wdata_in[i]; // RQ2 RQ5
        end
      end
    end
  endgenerate
endmodule

//--- hdl/podl_top.sv
// Pulse output data latch: enable, output data, next data and trigger select
// Assumes synchronous trigger pulses and a plain one-cycle register port
`timescale 1ns/10ps
`include "podl_params.svh"
module podl_top #(
  parameter int TRIG_COUNT = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [TRIG_COUNT-1:0] trigger_in,
  output logic [7:0] rdata_out,
  output logic [15:0] pulse_out
);
  // ****************************************
  // Registers
  // ****************************************
  podl_pkg::podl_byte_t next_enable_high;
  podl_pkg::podl_byte_t next_enable_low;
  podl_pkg::podl_byte_t next_data_high;
  podl_pkg::podl_byte_t next_data_low;
  podl_pkg::podl_byte_t output_control_reg;
  podl_pkg::podl_word_t enables;
  podl_pkg::podl_word_t next_bits;
  podl_pkg::podl_word_t out_bits;
  podl_pkg::podl_byte_t next_rdata;
  logic [3:0] group_trig;
  logic [3:0] group_wr;
  logic sel_enable_high;
  logic sel_enable_low;
  logic sel_data_high;
  logic sel_data_low;
  logic sel_next_high;
  logic sel_next_low;
  logic sel_control;

  // ****************************************
  // Write decode
  // ****************************************
  // One select per register keeps the write paths apart
  assign sel_enable_high = wr_in && (addr_in == `PODL_OFS_ENABLE_HIGH);
  assign sel_enable_low = wr_in && (addr_in == `PODL_OFS_ENABLE_LOW);
  assign sel_data_high = wr_in && (addr_in == `PODL_OFS_DATA_HIGH);
  assign sel_data_low = wr_in && (addr_in == `PODL_OFS_DATA_LOW);
  assign sel_next_high = wr_in && (addr_in == `PODL_OFS_NEXT_HIGH);
  assign sel_next_low = wr_in && (addr_in == `PODL_OFS_NEXT_LOW);
  assign sel_control = wr_in && (addr_in == `PODL_OFS_CONTROL);

  // ****************************************
  // Transfer enable registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      next_enable_high <= `PODL_RST_BYTE; // RQ3
    end else if (sel_enable_high) begin
      next_enable_high <= wdata_in; // RQ3
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      next_enable_low <= `PODL_RST_BYTE; // RQ3
    end else if (sel_enable_low) begin
      next_enable_low <= wdata_in; // RQ3
    end
  end

  // ****************************************
  // Next data and trigger select
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      next_data_high <= `PODL_RST_BYTE;
    end else if (sel_next_high) begin
      next_data_high <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      next_data_low <= `PODL_RST_BYTE;
    end else if (sel_next_low) begin
      next_data_low <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      output_control_reg <= `PODL_RST_BYTE;
    end else if (sel_control) begin
      output_control_reg <= wdata_in; // RQ7
    end
  end

  // ****************************************
  // Bit vectors per output position
  // ****************************************
  assign enables = {next_enable_high, next_enable_low};
  assign next_bits = {next_data_high, next_data_low};

  // ****************************************
  // Groups of four with own trigger select
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_grp
      logic [`PODL_SEL_BITS-1:0] trig_sel;
      // Control byte holds a 2-bit trigger select per group
      assign trig_sel = output_control_reg[2*g +: `PODL_SEL_BITS]; // RQ7
      // A select beyond the wired triggers never fires the group
      assign group_trig[g] = (int'(trig_sel) < TRIG_COUNT) ? trigger_in[trig_sel] : 1'b0; // RQ7 RQ8
      // Groups 0 and 1 sit in the low byte, 2 and 3 in the high byte
      assign group_wr[g] = (g < 2) ? sel_data_low : sel_data_high;
      podl_group #(.WIDTH(`PODL_GROUP_BITS)) u_grp (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .trigger_in(group_trig[g]),
        .enable_in(enables[4*g +: 4]),
        .next_in(next_bits[4*g +: 4]),
        .write_in(group_wr[g]),
        .wdata_in(wdata_in[4*(g%2) +: 4]),
        .data_out(out_bits[4*g +: 4])
      ); // RQ8
    end
  endgenerate

  assign pulse_out = out_bits; // RQ9

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped indexes and idle cycles read as zero
  always_comb begin
    next_rdata = `PODL_RST_BYTE;
    if (rd_in) begin
      case (addr_in)
        `PODL_OFS_ENABLE_HIGH: next_rdata = next_enable_high; // RQ3
        `PODL_OFS_ENABLE_LOW: next_rdata = next_enable_low; // RQ3
        `PODL_OFS_DATA_HIGH: next_rdata = out_bits[15:8]; // RQ6
        `PODL_OFS_DATA_LOW: next_rdata = out_bits[7:0]; // RQ6
        `PODL_OFS_NEXT_HIGH: next_rdata = next_data_high;
        `PODL_OFS_NEXT_LOW: next_rdata = next_data_low;
        `PODL_OFS_CONTROL: next_rdata = output_control_reg;
        default: next_rdata = `PODL_RST_BYTE;
      endcase
    end
  end

  // Read data stand for one cycle only, then return to zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= `PODL_RST_BYTE;
    end else begin
      rdata_out <= next_rdata; // RQ6
    end
  end
endmodule

//--- tb/podl_top_asserts.sv
// Port checker for the pulse output data latch
// Assumes it is bound onto podl_top and shares its clock
`timescale 1ns/10ps
module podl_top_chk #(parameter int TRIG_COUNT = 4) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [TRIG_COUNT-1:0] trigger_in,
  input wire logic [7:0] rdata_out,
  input wire logic [15:0] pulse_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rz; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("read data not idle");
  property p_hold; !wr_in && trigger_in == 0 |=> $stable(pulse_out); endproperty
  a_hold: assert property (p_hold) else $error("pins moved");
  property p_wl; wr_in && addr_in == 4'h3 && trigger_in == 0 |=> $stable(pulse_out[15:8]); endproperty
  a_wl: assert property (p_wl) else $error("high pins moved");
  property p_wh; wr_in && addr_in == 4'h2 && trigger_in == 0 |=> $stable(pulse_out[7:0]); endproperty
  a_wh: assert property (p_wh) else $error("low pins moved");
  property p_rl; rd_in && addr_in == 4'h3 |=> rdata_out == $past(pulse_out[7:0]); endproperty
  a_rl: assert property (p_rl) else $error("low read wrong");
  property p_rh; rd_in && addr_in == 4'h2 |=> rdata_out == $past(pulse_out[15:8]); endproperty
  a_rh: assert property (p_rh) else $error("high read wrong");
  property p_ru; rd_in && addr_in > 4'h6 |=> rdata_out == 8'h00; endproperty
  a_ru: assert property (p_ru) else $error("unmapped read");
  property p_wn; wr_in && addr_in != 4'h2 && addr_in != 4'h3 && trigger_in == 0 |=> $stable(pulse_out); endproperty
  a_wn: assert property (p_wn) else $error("pins moved on write");
endmodule
bind podl_top podl_top_chk #(.TRIG_COUNT(TRIG_COUNT)) chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .trigger_in(trigger_in), .rdata_out(rdata_out),
  .pulse_out(pulse_out));

//--- tb/podl_load.sv
// Load on the pulse output pins
// Assumes the pins are sampled on the block clock
`timescale 1ns/10ps
module podl_load (
  input wire logic clk_in,
  input wire logic [15:0] pins_in,
  output logic [15:0] level_out
);
  always_ff @(posedge clk_in) begin
    level_out <= pins_in;
  end
endmodule

//--- tb/tb_podl_top.sv
// Self-checking bench for the pulse output data latch
// Assumes register indexes 0 to 6 as laid out in the design's constants
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_podl_top;
  logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
  logic [3:0] addr_in = 0, trigger_in = 0;
  logic [7:0] wdata_in = 0, rdata_out;
  logic [15:0] pulse_out, level;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  podl_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .trigger_in(trigger_in), .rdata_out(rdata_out), .pulse_out(pulse_out));
  podl_load load_u (.clk_in(clk_in), .pins_in(pulse_out), .level_out(level));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task test_done;
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task pc(input logic [15:0] e);
    #1 `CHK(pulse_out, e)
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata_out, e)
  endtask
  task trg(input logic [3:0] m, input logic [15:0] e);
    @(posedge clk_in);
    trigger_in <= m;
    @(posedge clk_in);
    trigger_in <= 4'h0;
    pc(e);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'h00);
    rd(4'hf, 8'h00);
    wr(4'h3, 8'h05);
    pc(16'h0005);
    wr(4'h2, 8'h50);
    pc(16'h5005);
    wr(4'h1, 8'h0f);
    wr(4'h5, 8'haa);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'hf5);
    trg(4'h1, 16'h50fa);
    wr(4'h6, 8'h10);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'hff);
    rd(4'h1, 8'h0f);
    rd(4'h5, 8'haa);
    rd(4'h6, 8'h10);
    wr(4'h4, 8'h3c);
    rd(4'h4, 8'h3c);
    trg(4'h1, 16'h30fa);
    trg(4'h2, 16'h3cfa);
    wr(4'h2, 8'h00);
    pc(16'h3cfa);
    wr(4'h4, 8'hc3);
    wr(4'h6, 8'he4);
    trg(4'h4, 16'h33fa);
    trg(4'h8, 16'hc3fa);
    @(posedge clk_in);
    #1 `CHK(level, 16'hc3fa)
    test_done;
  end
endmodule
